// >>> verilog/apmc_pkg.sv
// Package of shared constants for the converter power-state control ends.
package apmc_pkg;

  // ==========================================================================
  // Timing figures and their cycle counts at the 100 MHz clock.
  // ==========================================================================
  localparam int unsigned CLK_PERIOD_PS      = 10000;  // Clock period in ps.
  localparam int unsigned T_CONV_MAX_NS      = 310;    // Longest conversion.
  localparam int unsigned T_NAP_WAKE_NS      = 200;    // Least high time.
  localparam int unsigned T_CNV_RELEASE_NS   = 40;     // Early release limit.
  localparam int unsigned T_RECOVER_MS       = 5;      // Shutdown recovery.
  localparam int unsigned T_SUPPLY_MIN_MV    = 2500;   // Power-on reset level.

  // Conversion, release and recovery times round down; only the nap wake time rounds up.
  localparam int unsigned CONV_CYCLES =
    (T_CONV_MAX_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned NAP_WAKE_CYCLES =
    (T_NAP_WAKE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned RELEASE_CYCLES =
    (T_CNV_RELEASE_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned RECOVER_CYCLES =
    (T_RECOVER_MS * 1000000000 / CLK_PERIOD_PS);

  // Counter width shared by both ends.
  localparam int unsigned CNT_W = 20;

  // ==========================================================================
  // Device power-state machine.
  // ==========================================================================
  typedef enum logic [2:0] {
    APMC_ST_RESET    = 3'b000,  // Held by the power-on reset.
    APMC_ST_IDLE     = 3'b001,  // Awake, waiting for a start edge.
    APMC_ST_CONVERT  = 3'b010,  // Conversion in progress.
    APMC_ST_NAP      = 3'b011,  // Partly powered down between conversions.
    APMC_ST_SHUTDOWN = 3'b100,  // All functions off.
    APMC_ST_WAKEUP   = 3'b101   // Powering up after shutdown.
  } apmc_dev_state_e;

  // Host controller state machine.
  typedef enum logic [2:0] {
    APMC_HS_IDLE     = 3'b000,  // Ready for a request; start high after reset, low after a conversion.
    APMC_HS_PRECHG   = 3'b001,  // Holding start high for the wake time.
    APMC_HS_LOW      = 3'b010,  // Start line driven low.
    APMC_HS_WAIT     = 3'b011,  // Waiting for busy to fall.
    APMC_HS_DOWN     = 3'b100,  // Power-down pin raised.
    APMC_HS_RECOVER  = 3'b101   // Waiting out recovery after shutdown.
  } apmc_host_state_e;

endpackage

// >>> verilog/apmc_if.sv
// Interface carrying the pins between the converter and its controller.
`timescale 1ns/1ps
`default_nettype none
interface apmc_if;
  logic convert_start_n;  // Start line; falling edge starts a conversion.
  logic power_down_pin;   // High requests power shutdown.
  logic busy;             // High while a conversion runs.
  logic [17:0] result;    // Last conversion result.

  // Converter end.
  modport dev (
    input  convert_start_n,
    input  power_down_pin,
    output busy,
    output result
  );

  // Controller end.
  modport host (
    output convert_start_n,
    output power_down_pin,
    input  busy,
    input  result
  );
endinterface
`default_nettype wire

// >>> verilog/apmc_dev.sv
// Converter end: power-on reset, nap, shutdown and conversion timing.
`timescale 1ns/1ps
`default_nettype none
module apmc_dev
  import apmc_pkg::*;
#(
  parameter int unsigned RESULT_W = 18  // Width of a conversion result.
) (
  // Clock and synchronous reset.
  input  wire logic                i_clk,
  input  wire logic                i_rst_n,
  // Supply monitor: high while the supply is at or above 2.5 V.
  input  wire logic                i_supply_ok,
  // Sampled analogue value that the conversion stands for.
  input  wire logic [RESULT_W-1:0] i_sample,
  // Pins toward the controller.
  apmc_if.dev                      pins,
  // Power-state view for the rest of the chip.
  output logic                     o_nap,
  output logic                     o_shutdown,
  output logic                     o_ref_on
);
  import apmc_pkg::*;

  // ==========================================================================
  // Elaboration checks.
  // ==========================================================================
  if (RESULT_W != 18) begin : g_bad_w
    $error("Result width must match the pin bus width of 18.");
  end
  if (CONV_CYCLES < 1 || CONV_CYCLES >= (1 << CNT_W)) begin : g_bad_conv
    $error("Conversion cycle count does not fit its counter.");
  end

  // ==========================================================================
  // Pin synchronisers: two flops before any logic reads the pins.
  // ==========================================================================
  logic [1:0] cnv_sync_reg;   // Start line synchroniser.
  logic [1:0] cnv_sync_next;  // Next value of the start synchroniser.
  logic [1:0] pd_sync_reg;    // Power-down synchroniser.
  logic [1:0] pd_sync_next;   // Next value of the power-down synchroniser.
  logic [1:0] sup_sync_reg;   // Supply monitor synchroniser.
  logic [1:0] sup_sync_next;  // Next value of the supply synchroniser.
  logic       cnv_last_reg;   // Previous synchronised start level.
  logic       cnv_last_next;  // Next value of the previous start level.

  // Shift the pin levels in one step per clock.
  always_comb begin
    cnv_sync_next = {cnv_sync_reg[0], pins.convert_start_n};
    pd_sync_next  = {pd_sync_reg[0], pins.power_down_pin};
    sup_sync_next = {sup_sync_reg[0], i_supply_ok};
    cnv_last_next = cnv_sync_reg[1];
  end

  // Register the synchronisers; start line idles high, supply low.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnv_sync_reg <= 2'h3;
      pd_sync_reg  <= 2'h0;
      sup_sync_reg <= 2'h0;
      cnv_last_reg <= 1'b1;
    end else begin
      cnv_sync_reg <= cnv_sync_next;
      pd_sync_reg  <= pd_sync_next;
      sup_sync_reg <= sup_sync_next;
      cnv_last_reg <= cnv_last_next;
    end
  end

  logic cnv_level;  // Synchronised start line level.
  logic cnv_fall;   // One-cycle pulse on a falling start edge.
  logic pd_level;   // Synchronised power-down level.
  logic por_active; // Internal power-on reset is asserted.

  assign cnv_level  = cnv_sync_reg[1];
  assign cnv_fall   = cnv_last_reg && !cnv_sync_reg[1];
  assign pd_level   = pd_sync_reg[1];
  assign por_active = !sup_sync_reg[1];

  // ==========================================================================
  // Power-state machine with conversion timer and result latch.
  // ==========================================================================
  apmc_dev_state_e     state_reg;   // Present power state.
  apmc_dev_state_e     state_next;  // Next power state.
  logic [CNT_W-1:0]    cnt_reg;     // Conversion cycle counter.
  logic [CNT_W-1:0]    cnt_next;    // Next counter value.
  logic                busy_reg;    // Busy output flop.
  logic                busy_next;   // Next busy value.
  logic [RESULT_W-1:0] data_reg;    // Result output flop.
  logic [RESULT_W-1:0] data_next;   // Next result value.

  // Work out the next state, counter, busy level and result.
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    busy_next  = busy_reg;
    data_next  = data_reg;
    case (state_reg)
      APMC_ST_RESET: begin
        // Leave reset on its own once the supply is back.
        busy_next = 1'b0;
        if (!por_active) begin
          state_next = APMC_ST_IDLE;
        end
      end
      APMC_ST_IDLE: begin
        // Awake and fully powered, so the first result is good.
        if (pd_level) begin
          state_next = APMC_ST_SHUTDOWN;
        end else if (cnv_fall) begin
          state_next = APMC_ST_CONVERT;
          busy_next  = 1'b1;
          cnt_next   = '0;
        end
      end
      APMC_ST_CONVERT: begin
        // Start edges are ignored; power-down waits for the end.
        if (cnt_reg == CNT_W'(CONV_CYCLES - 1)) begin
          busy_next = 1'b0;
          data_next = i_sample;
          if (pd_level) begin
            state_next = APMC_ST_SHUTDOWN;
          end else if (!cnv_level) begin
            state_next = APMC_ST_NAP;
          end else begin
            state_next = APMC_ST_IDLE;
          end
        end else begin
          cnt_next = cnt_reg + CNT_W'(1);
        end
      end
      APMC_ST_NAP: begin
        // Wake when the start line returns high.
        if (pd_level) begin
          state_next = APMC_ST_SHUTDOWN;
        end else if (cnv_level) begin
          state_next = APMC_ST_IDLE;
        end
      end
      APMC_ST_SHUTDOWN: begin
        // Every start request is dropped here.
        if (!pd_level) begin
          state_next = APMC_ST_WAKEUP;
        end
      end
      APMC_ST_WAKEUP: begin
        // Power comes back up; a new start waits for a fresh high level.
        if (pd_level) begin
          state_next = APMC_ST_SHUTDOWN;
        end else if (cnv_level) begin
          state_next = APMC_ST_IDLE;
        end
      end
      default: begin
        state_next = APMC_ST_RESET;
      end
    endcase
    if (por_active) begin
      // The power-on reset overrides state, counter and busy, but not the result.
      state_next = APMC_ST_RESET;
      busy_next  = 1'b0;
      cnt_next   = '0;
    end
  end

  // Register the power state; reset puts the logic in awake idle.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_reg <= APMC_ST_IDLE;
      cnt_reg   <= '0;
      busy_reg  <= 1'b0;
      data_reg  <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      busy_reg  <= busy_next;
      data_reg  <= data_next;
    end
  end

  // ==========================================================================
  // Outputs.
  // ==========================================================================
  assign pins.busy   = busy_reg;
  assign pins.result = data_reg;
  assign o_nap       = (state_reg == APMC_ST_NAP);
  assign o_shutdown  = (state_reg == APMC_ST_SHUTDOWN);
  assign o_ref_on    = (state_reg != APMC_ST_SHUTDOWN) &&
                       (state_reg != APMC_ST_RESET);

endmodule
`default_nettype wire

// >>> verilog/apmc_host.sv
// Controller end: drives start and power-down pins and collects results.
`timescale 1ns/1ps
`default_nettype none
module apmc_host
  import apmc_pkg::*;
#(
  parameter int unsigned RECOVER_CNT = RECOVER_CYCLES  // Shutdown recovery.
) (
  // Clock and synchronous reset.
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // User requests.
  input  wire logic        i_conv_req,   // High while ready: start one; held high, it starts one after another.
  input  wire logic        i_sleep,      // Level: keep converter shut down.
  // User answers.
  output logic             o_ready,      // High when a request is taken.
  output logic             o_valid,      // One-cycle pulse with new data.
  output logic [17:0]      o_data,       // Last collected result.
  // Pins toward the converter.
  apmc_if.host             pins
);
  import apmc_pkg::*;

  // ==========================================================================
  // Elaboration checks.
  // ==========================================================================
  if (RECOVER_CNT < 1 || RECOVER_CNT >= (1 << CNT_W)) begin : g_bad_rec
    $error("Recovery count does not fit its counter.");
  end

  // ==========================================================================
  // Busy synchroniser; the result is read straight from the pins.
  // ==========================================================================
  logic [1:0] busy_sync_reg;   // Busy synchroniser.
  logic [1:0] busy_sync_next;  // Next busy synchroniser value.

  // Shift busy through two flops.
  always_comb begin
    busy_sync_next = {busy_sync_reg[0], pins.busy};
  end

  // Register busy; the converter is idle at reset.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      busy_sync_reg <= 2'h0;
    end else begin
      busy_sync_reg <= busy_sync_next;
    end
  end

  // ==========================================================================
  // Pin sequencing state machine.
  // ==========================================================================
  apmc_host_state_e  state_reg;   // Present state.
  apmc_host_state_e  state_next;  // Next state.
  logic [CNT_W-1:0]  cnt_reg;     // Timing counter.
  logic [CNT_W-1:0]  cnt_next;    // Next counter value.
  logic              cnv_reg;     // Start pin flop.
  logic              cnv_next;    // Next start pin value.
  logic              pd_reg;      // Power-down pin flop.
  logic              pd_next;     // Next power-down pin value.
  logic              valid_reg;   // Data valid pulse flop.
  logic              valid_next;  // Next valid value.
  logic [17:0]       data_reg;    // Collected result.
  logic [17:0]       data_next;   // Next collected result.

  // Sequence the pins and collect results.
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    cnv_next   = cnv_reg;
    pd_next    = pd_reg;
    valid_next = 1'b0;
    data_next  = data_reg;
    case (state_reg)
      APMC_HS_IDLE: begin
        // Data was read already, so shutdown may be raised here.
        if (i_sleep) begin
          pd_next    = 1'b1;
          state_next = APMC_HS_DOWN;
        end else if (i_conv_req) begin
          cnv_next   = 1'b1;
          cnt_next   = '0;
          state_next = APMC_HS_PRECHG;
        end
      end
      APMC_HS_PRECHG: begin
        // Hold start high long enough to leave nap.
        if (cnt_reg >= CNT_W'(NAP_WAKE_CYCLES - 1)) begin
          cnv_next   = 1'b0;
          cnt_next   = '0;
          state_next = APMC_HS_LOW;
        end else begin
          cnt_next = cnt_reg + CNT_W'(1);
        end
      end
      APMC_HS_LOW: begin
        // Keep start low until busy falls: returning late is allowed.
        cnt_next   = '0;
        state_next = APMC_HS_WAIT;
      end
      APMC_HS_WAIT: begin
        // Wait for busy to rise and fall, leaving start low for nap.
        if (busy_sync_reg[1]) begin
          cnt_next = CNT_W'(1);
        end else if (cnt_reg != '0) begin
          data_next  = pins.result;
          valid_next = 1'b1;
          state_next = APMC_HS_IDLE;
        end
      end
      APMC_HS_DOWN: begin
        // Release shutdown when the user no longer asks for sleep.
        if (!i_sleep) begin
          pd_next    = 1'b0;
          cnt_next   = '0;
          state_next = APMC_HS_RECOVER;
        end
      end
      APMC_HS_RECOVER: begin
        // Let the reference settle before the next start.
        if (cnt_reg >= CNT_W'(RECOVER_CNT - 1)) begin
          state_next = APMC_HS_IDLE;
        end else begin
          cnt_next = cnt_reg + CNT_W'(1);
        end
      end
      default: begin
        state_next = APMC_HS_IDLE;
      end
    endcase
  end

  // Register the sequencer; start line idles high, power-down off.
  // A low start line at reset would look like a falling edge to the
  // converter once reset ends and start a conversion nobody asked for.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_reg <= APMC_HS_IDLE;
      cnt_reg   <= '0;
      cnv_reg   <= 1'b1;
      pd_reg    <= 1'b0;
      valid_reg <= 1'b0;
      data_reg  <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      cnv_reg   <= cnv_next;
      pd_reg    <= pd_next;
      valid_reg <= valid_next;
      data_reg  <= data_next;
    end
  end

  // ==========================================================================
  // Outputs.
  // ==========================================================================
  assign pins.convert_start_n = cnv_reg;
  assign pins.power_down_pin  = pd_reg;
  assign o_ready = (state_reg == APMC_HS_IDLE);
  assign o_valid = valid_reg;
  assign o_data  = data_reg;

endmodule
`default_nettype wire

// >>> testbench/apmc_checker.sv
// Checker of the pin timing between the converter and its controller.
`timescale 1ns/1ps
`default_nettype none
module apmc_checker
  import apmc_pkg::*;
(
  // Clock and reset.
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // Pins between the two ends.
  input  wire logic        convert_start_n,
  input  wire logic        power_down_pin,
  input  wire logic        busy,
  input  wire logic [17:0] result
);
  localparam int CONV_N = CONV_CYCLES;      // Busy length in cycles.
  localparam int WAKE_N = NAP_WAKE_CYCLES;  // Least start high time.

  logic [5:0] busy_cnt_reg;   // Cycles busy has been high so far.
  logic [5:0] busy_cnt_next;  // Next value of the busy count.
  logic [5:0] hi_cnt_reg;     // Cycles start has been high, saturating.
  logic [5:0] hi_cnt_next;    // Next value of the high count.

  // ==========================================================================
  // Helper counters.
  // ==========================================================================
  // Counts busy and start-high runs so busy length is checked exactly, start-high length as a minimum.
  always_comb begin
    busy_cnt_next = busy ? busy_cnt_reg + 6'h01 : 6'h00;
    hi_cnt_next   = hi_cnt_reg;
    if (!convert_start_n) begin
      hi_cnt_next = 6'h00;
    end else if (hi_cnt_reg != 6'h3f) begin
      hi_cnt_next = hi_cnt_reg + 6'h01;
    end
  end

  // Registers the counters; reset clears both runs.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      busy_cnt_reg <= 6'h00;
      hi_cnt_reg   <= 6'h00;
    end else begin
      busy_cnt_reg <= busy_cnt_next;
      hi_cnt_reg   <= hi_cnt_next;
    end
  end

  // ==========================================================================
  // Properties.
  // ==========================================================================
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  property p_busy_len;
    $fell(busy) |-> busy_cnt_reg == CONV_N;
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("busy length differs from conversion time");

  property p_busy_max;
    busy |-> busy_cnt_reg < CONV_N;
  endproperty
  a_busy_max: assert property (p_busy_max)
    else $error("busy stays high too long");

  property p_start_cause;
    $rose(busy) |-> !convert_start_n && !$past(convert_start_n)
      && !$past(convert_start_n, 2);
  endproperty
  a_start_cause: assert property (p_start_cause)
    else $error("busy rose without a start fall");

  property p_start_ans;
    $fell(convert_start_n) && !busy && !power_down_pin |-> ##[1:5] busy;
  endproperty
  a_start_ans: assert property (p_start_ans)
    else $error("start fall not answered by busy");

  property p_pd_block;
    power_down_pin && $past(power_down_pin, 3) |-> !$rose(busy);
  endproperty
  a_pd_block: assert property (p_pd_block)
    else $error("conversion began in shutdown");

  property p_rst_idle;
    $rose(i_rst_n) |-> !busy;
  endproperty
  a_rst_idle: assert property (p_rst_idle)
    else $error("busy high after reset");

  property p_wake_time;
    $fell(convert_start_n) |-> hi_cnt_reg >= WAKE_N;
  endproperty
  a_wake_time: assert property (p_wake_time)
    else $error("start high time too short");

  property p_release;
    $rose(convert_start_n) |-> !busy;
  endproperty
  a_release: assert property (p_release)
    else $error("start raised during conversion");

  property p_pd_read;
    $rose(power_down_pin) |-> !busy;
  endproperty
  a_pd_read: assert property (p_pd_read)
    else $error("power-down raised during conversion");

  property p_recover;
    $fell(power_down_pin) |=> !$fell(convert_start_n) [*8];
  endproperty
  a_recover: assert property (p_recover)
    else $error("conversion requested during recovery");

  property p_result_hold;
    !$fell(busy) |-> $stable(result);
  endproperty
  a_result_hold: assert property (p_result_hold)
    else $error("result changed outside a conversion end");

  // Main scenarios: a conversion ends, shutdown is entered and left.
  c_conv_end: cover property ($fell(busy));
  c_pd_on: cover property ($rose(power_down_pin));
  c_pd_off: cover property ($fell(power_down_pin));
endmodule
`default_nettype wire

// >>> testbench/test_adc_power_mode_control.sv
// Testbench of both converter ends and of a bench-driven converter.
`timescale 1ns/1ps
`default_nettype none
module test_adc_power_mode_control;
  import apmc_pkg::*;
  logic        i_clk = 1'b0;     // Bench clock.
  logic        i_rst_n = 1'b0;   // Shared synchronous reset.
  logic        conv_req = 1'b0;  // Host user request.
  logic        sleep = 1'b0;     // Host user sleep level.
  logic [17:0] sample_a = 18'h0; // Analogue value of the paired end.
  logic [17:0] sample_b = 18'h0; // Analogue value of the driven end.
  logic        supply_b = 1'b1;  // Supply monitor of the driven end.
  logic        ready, valid, nap_a, shut_a, ref_a, nap_b, shut_b, ref_b;
  logic [17:0] data;             // Host collected result.
  logic [17:0] s;                // Saved expected result.
  int          errors = 0;
  int          comparisons = 0;
  int          n;                // Measured count.
  apmc_if pins_a ();             // Pins joining host and converter.
  apmc_if pins_b ();             // Pins driven by the bench.

  // Clock of 10 ns period.
  always #5 i_clk = ~i_clk;

  apmc_dev i_apmc_dev (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_supply_ok(1'b1),
    .i_sample(sample_a), .pins(pins_a), .o_nap(nap_a), .o_shutdown(shut_a),
    .o_ref_on(ref_a));
  apmc_host #(.RECOVER_CNT(8)) i_apmc_host (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_conv_req(conv_req), .i_sleep(sleep), .o_ready(ready),
    .o_valid(valid), .o_data(data), .pins(pins_a));
  apmc_dev i_apmc_dev_b (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_supply_ok(supply_b), .i_sample(sample_b), .pins(pins_b),
    .o_nap(nap_b), .o_shutdown(shut_b), .o_ref_on(ref_b));
  apmc_checker i_apmc_checker (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .convert_start_n(pins_a.convert_start_n),
    .power_down_pin(pins_a.power_down_pin), .busy(pins_a.busy),
    .result(pins_a.result));

  // Compares one value and counts it.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Waits a number of falling edges.
  task automatic cyc(input int k);
    repeat (k) @(negedge i_clk);
  endtask

  // One conversion through the host user port.
  task automatic host_conv(input logic [17:0] v);
    int k;
    k = 0;
    sample_a = v;
    while (ready !== 1'b1 && k < 100) begin
      cyc(1);
      k++;
    end
    conv_req = 1'b1;
    cyc(1);
    conv_req = 0;
    k = 0;
    while (valid !== 1'b1 && k < 200) begin
      cyc(1);
      k++;
    end
    chk(data, v);
  endtask

  // One conversion on the driven end; may raise power-down mid-way.
  task automatic conv_b(input logic [17:0] v, input logic pd_mid);
    int k;
    k = 0;
    sample_b = v;
    pins_b.convert_start_n = 1'b1;
    cyc(NAP_WAKE_CYCLES + 4);
    pins_b.convert_start_n = 1'b0;
    while (pins_b.busy !== 1'b1 && k < 10) begin
      cyc(1);
      k++;
    end
    pins_b.power_down_pin = pd_mid;
    n = 0;
    while (pins_b.busy === 1'b1 && n < 100) begin
      cyc(1);
      n++;
    end
    chk(n, CONV_CYCLES);
    chk(pins_b.result, v);
  endtask

  // Checks that the driven end starts nothing for a while.
  task automatic quiet(input int k);
    n = 0;
    repeat (k) begin
      cyc(1);
      if (pins_b.busy !== 1'b0) n++;
    end
    chk(n, 0);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Cuts a hang short well past the expected run length.
  initial begin
    cyc(20000);
    errors++;
    finish_test();
  end

  // Main sequence.
  initial begin
    pins_b.convert_start_n = 1'b1;
    pins_b.power_down_pin = 1'b0;
    void'($urandom(14486));
    repeat (3) @(posedge i_clk);
    cyc(1);
    i_rst_n = 1'b1;
    // Back-to-back host conversions with extreme and random values.
    host_conv(18'h3ffff);
    host_conv(18'h00000);
    for (int i = 0; i < 4; i++) begin
      host_conv(18'($urandom));
    end
    chk(nap_a, 1);
    $display("test host conversions done");
    // Host sleep, then recovery and a new conversion.
    sleep = 1'b1;
    cyc(6);
    chk(pins_a.power_down_pin, 1);
    chk(shut_a, 1);
    chk(ref_a, 0);
    sleep = 1'b0;
    cyc(6);
    chk(shut_a, 0);
    host_conv(18'($urandom));
    $display("test host sleep done");
    // Nap after a conversion with start held low, then wake from nap.
    conv_b(18'($urandom), 1'b0);
    cyc(4);
    chk(nap_b, 1);
    conv_b(18'h2aaaa, 1'b0);
    $display("test nap done");
    // Power-down raised mid-conversion; requests ignored while shut down.
    s = 18'($urandom);
    conv_b(s, 1'b1);
    cyc(4);
    chk(shut_b, 1);
    chk(ref_b, 0);
    pins_b.convert_start_n = 1'b1;
    cyc(25);
    pins_b.convert_start_n = 1'b0;
    quiet(40);
    pins_b.power_down_pin = 1'b0;
    pins_b.convert_start_n = 1'b1;
    cyc(6);
    chk(shut_b, 0);
    chk(ref_b, 1);
    chk(pins_b.result, s);
    conv_b(18'($urandom), 1'b0);
    $display("test shutdown done");
    // Low supply holds the converter in reset; return reinitialises it.
    pins_b.convert_start_n = 1'b1;
    supply_b = 1'b0;
    cyc(6);
    chk(ref_b, 0);
    chk(pins_b.busy, 0);
    pins_b.convert_start_n = 1'b0;
    quiet(20);
    supply_b = 1'b1;
    pins_b.convert_start_n = 1'b1;
    cyc(6);
    chk(ref_b, 1);
    chk(nap_b, 0);
    conv_b(18'($urandom), 1'b0);
    $display("test supply reset done");
    finish_test();
  end
endmodule
`default_nettype wire
